//--- common/pevc_pkg.sv
// Shared constants for the pipeline event counter block
package pevc_pkg;
    // Counter widths: counter 0 carries out of bit 15 or 11, counter 1 out of bit 11 or 7
    localparam int CNT0_W = 16;
    localparam int CNT1_W = 12;
    localparam int CNT0_LONG_BIT = 15;
    localparam int CNT0_SHORT_BIT = 11;
    localparam int CNT1_LONG_BIT = 11;
    localparam int CNT1_SHORT_BIT = 7;
    // Enable field position inside the instruction unit control register
    localparam int ENABLE_HI = 45;
    localparam int ENABLE_LO = 44;
    // Interrupt request delay after the crossing event
    localparam int IRQ_DELAY_CYCLES = 6;
    localparam logic [15:0] CNT0_RESET = 16'h0000;
    localparam logic [11:0] CNT1_RESET = 12'h000;
    // Counter 0 source codes (upper three bits unless noted)
    localparam logic [2:0] SRC0_ISSUE_HALF = 3'h0;
    localparam logic [2:0] SRC0_DRY = 3'h1;
    localparam logic [2:0] SRC0_LOAD = 3'h2;
    localparam logic [2:0] SRC0_FROZEN = 3'h3;
    localparam logic [2:0] SRC0_BRANCH = 3'h4;
    localparam logic [2:0] SRC0_CYCLE_GRP = 3'h5;
    localparam logic [2:0] SRC0_NOISSUE_HALF = 3'h6;
    localparam logic [2:0] SRC0_EXT = 3'h7;
    localparam logic [3:0] SRC0_PRIV = 4'hb;
    localparam logic [3:0] SRC0_CYCLES = 4'ha;
    // Counter 1 source codes
    localparam logic [2:0] SRC1_DMISS = 3'h0;
    localparam logic [2:0] SRC1_IMISS = 3'h1;
    localparam logic [2:0] SRC1_DUAL = 3'h2;
    localparam logic [2:0] SRC1_MISPRED = 3'h3;
    localparam logic [2:0] SRC1_FP_OP = 3'h4;
    localparam logic [2:0] SRC1_INT_OP = 3'h5;
    localparam logic [2:0] SRC1_STORE = 3'h6;
    localparam logic [2:0] SRC1_EXT = 3'h7;
endpackage

//--- logic/pevc_sync.sv
// Two-flop synchroniser for the external event pins
`timescale 1ns/1ps
module pevc_sync #(
    parameter int WIDTH = 2
) (
    // Clock and reset
    input wire logic clk_in,
    input wire logic rst_in,
    // Data
    input wire logic [WIDTH-1:0] async_in,
    output logic [WIDTH-1:0] sync_out
);
    logic [WIDTH-1:0] meta_q;

    always_ff @(posedge clk_in or posedge rst_in) begin
        if (rst_in) begin
            meta_q <= '0;
            sync_out <= '0;
        end else begin
            meta_q <= async_in;
            sync_out <= meta_q;
        end
    end
endmodule

//--- logic/pevc_counter.sv
// One event counter with carry detect at a selectable bit and delayed request
`timescale 1ns/1ps
module pevc_counter #(
    parameter int WIDTH = 16,
    parameter int LONG_BIT = 15,
    parameter int SHORT_BIT = 11,
    parameter int DELAY = 6
) (
    // Clock and reset
    input wire logic clk_in,
    input wire logic rst_in,
    // Control
    input wire logic count_in,
    input wire logic short_in,
    // Crossing pulse, delayed
    output logic cross_out
);
    logic [WIDTH-1:0] cnt_q;
    logic [WIDTH-1:0] cnt_d;
    logic [DELAY-2:0] pipe_q;
    logic carry;

    // Free-running binary count; no reload on crossing keeps later events
    always_comb begin
        cnt_d = cnt_q + WIDTH'(1);
    end

    assign carry = count_in &&
        (short_in ? (cnt_q[SHORT_BIT:0] == '1) : (cnt_q[LONG_BIT:0] == '1)); // R26

    always_ff @(posedge clk_in or posedge rst_in) begin
        if (rst_in) begin
            cnt_q <= '0; // R1
        end else if (count_in) begin
            cnt_q <= cnt_d; // R8
        end
    end

    // Carry travels DELAY-1 stages; the sticky request flop adds the last one,
    // so the request stands DELAY cycles after the event
    always_ff @(posedge clk_in or posedge rst_in) begin
        if (rst_in) begin
            pipe_q <= '0;
        end else begin
            pipe_q <= {pipe_q[DELAY-3:0], carry}; // R7
        end
    end

    assign cross_out = pipe_q[DELAY-2];
endmodule

//--- logic/pevc_top.sv
// Pipeline event counters: source select, counting and interrupt requests
//
// Functional notes
// R1: Counters clear to zero at power-up only, never otherwise.
// R2: No port exposes a counter value; only interrupt requests are visible.
// R3: Counting enabled by a two-bit field at control bits 45:44.
// R4: Both enable bits clear stops both counters; either set runs both.
// R5: Counting continues through interrupts and source changes.
// R6: Each execution attempt may be counted, so reissued loads count twice.
// R7: Interrupt request rises exactly six cycles after the crossing event.
// R8: Events after a crossing keep counting toward the next request.
// R9: Crossings stay pending; only a full wrap while a request is pending loses one.
// R10: At most twelve instructions complete before service starts.
// R11: Icache miss counting lets no instruction complete before interrupt.
// R12: Branch mispredict counting lets at most two instructions complete.
// R13: Counter 0 codes 000X issues halved, 001X dry pipeline cycles.
// R14: Counter 0 codes 010X loads, 011X frozen pipeline cycles.
// R15: Counter 0 code 100X counts branches, jumps and exception returns.
// R16: Counter 0 code 1011 privileged-mode cycles, 1010 every cycle.
// R17: Counter 0 code 110X counts non-issue cycles halved.
// R18: Code 111X / 111 count that counter's external event pin.
// R19: Counter 1 codes 000 dcache miss, 001 icache miss, 010 dual issue.
// R20: Counter 1 code 011 counts branch and jump/return mispredictions.
// R21: Counter 1 code 100 FP operates, 101 integer operates.
// R22: Counter 1 code 110 counts stores.
// R23: Counter 0 requests every 2^16 events, or 2^12 with threshold bit.
// R24: Counter 1 requests every 2^12 events, or 2^8 with threshold bit.
// R25: A pending request holds until software writes zero to its clear bit.
// R26: Binary counters flag each carry at the chosen bit, no reload.
`timescale 1ns/1ps
module pevc_top
    import pevc_pkg::*;
#(
    parameter int CNT0_WIDTH = pevc_pkg::CNT0_W,
    parameter int CNT1_WIDTH = pevc_pkg::CNT1_W
) (
    // Clock and reset
    input wire logic clk_in,
    input wire logic rst_in,
    // Control register fields
    input wire logic [pevc_pkg::ENABLE_HI:pevc_pkg::ENABLE_LO] counter_enable_pair_in,
    input wire logic [3:0] counter0_source_select_in,
    input wire logic [2:0] counter1_source_select_in,
    input wire logic counter0_threshold_select_in,
    input wire logic counter1_threshold_select_in,
    // Interrupt clear register write (active-zero bits clear)
    input wire logic interrupt_clear_register_wr_in,
    input wire logic interrupt_clear_counter0_in,
    input wire logic interrupt_clear_counter1_in,
    // Pipeline events
    input wire logic [1:0] issue_count_in,
    input wire logic dry_cycle_in,
    input wire logic load_in,
    input wire logic frozen_cycle_in,
    input wire logic branch_in,
    input wire logic privileged_code_mode_in,
    input wire logic dcache_miss_in,
    input wire logic icache_miss_in,
    input wire logic mispredict_in,
    input wire logic fp_operate_in,
    input wire logic int_operate_in,
    input wire logic store_in,
    // External event pins
    input wire logic [1:0] external_event_pins_in,
    // Interrupt requests
    output logic counter0_irq_out,
    output logic counter1_irq_out
);
    import pevc_pkg::*;

    logic [1:0] ext_sync;
    logic counting;
    logic ev0;
    logic ev1;
    logic half_q;
    logic cross0;
    logic cross1;
    logic clr0;
    logic clr1;

    pevc_sync #(.WIDTH(2)) u_sync (
        .clk_in(clk_in),
        .rst_in(rst_in),
        .async_in(external_event_pins_in),
        .sync_out(ext_sync)
    );

    assign counting = |counter_enable_pair_in; // R3 R4

    // Halving toggle shared by the two halved sources; it never resets except
    // at power-up, so fractional halves carry across source changes.
    always_ff @(posedge clk_in or posedge rst_in) begin
        if (rst_in) begin
            half_q <= 1'b0;
        end else if (counting) begin
            unique case (counter0_source_select_in[3:1])
                SRC0_ISSUE_HALF: half_q <= half_q ^ (issue_count_in == 2'd1); // R13
                SRC0_NOISSUE_HALF: half_q <= half_q ^ (issue_count_in == 2'd0); // R17
                default: half_q <= half_q;
            endcase
        end
    end

    // Counter 0 source select; loads are counted per attempt as offered
    always_comb begin
        unique case (counter0_source_select_in[3:1])
            SRC0_ISSUE_HALF: ev0 = (issue_count_in == 2'd2) ||
                ((issue_count_in == 2'd1) && half_q); // R13
            SRC0_DRY: ev0 = dry_cycle_in; // R13
            SRC0_LOAD: ev0 = load_in; // R14 R6
            SRC0_FROZEN: ev0 = frozen_cycle_in; // R14
            SRC0_BRANCH: ev0 = branch_in; // R15
            SRC0_CYCLE_GRP: ev0 = (counter0_source_select_in == SRC0_PRIV) ?
                privileged_code_mode_in : 1'b1; // R16
            SRC0_NOISSUE_HALF: ev0 = (issue_count_in == 2'd0) && half_q; // R17
            SRC0_EXT: ev0 = ext_sync[0]; // R18
            default: ev0 = 1'b0;
        endcase
    end

    // Counter 1 source select
    always_comb begin
        unique case (counter1_source_select_in)
            SRC1_DMISS: ev1 = dcache_miss_in; // R19
            SRC1_IMISS: ev1 = icache_miss_in; // R19 R11
            SRC1_DUAL: ev1 = (issue_count_in == 2'd2); // R19
            SRC1_MISPRED: ev1 = mispredict_in; // R20 R12
            SRC1_FP_OP: ev1 = fp_operate_in; // R21
            SRC1_INT_OP: ev1 = int_operate_in; // R21
            SRC1_STORE: ev1 = store_in; // R22
            SRC1_EXT: ev1 = ext_sync[1]; // R18
            default: ev1 = 1'b0;
        endcase
    end

    pevc_counter #(
        .WIDTH(CNT0_WIDTH),
        .LONG_BIT(CNT0_LONG_BIT),
        .SHORT_BIT(CNT0_SHORT_BIT),
        .DELAY(IRQ_DELAY_CYCLES)
    ) u_cnt0 (
        .clk_in(clk_in),
        .rst_in(rst_in),
        .count_in(counting && ev0), // R5
        .short_in(counter0_threshold_select_in), // R23
        .cross_out(cross0)
    );

    pevc_counter #(
        .WIDTH(CNT1_WIDTH),
        .LONG_BIT(CNT1_LONG_BIT),
        .SHORT_BIT(CNT1_SHORT_BIT),
        .DELAY(IRQ_DELAY_CYCLES)
    ) u_cnt1 (
        .clk_in(clk_in),
        .rst_in(rst_in),
        .count_in(counting && ev1),
        .short_in(counter1_threshold_select_in), // R24
        .cross_out(cross1)
    );

    assign clr0 = interrupt_clear_register_wr_in && !interrupt_clear_counter0_in;
    assign clr1 = interrupt_clear_register_wr_in && !interrupt_clear_counter1_in;

    // Sticky requests; a new crossing in the clear cycle wins over the clear
    always_ff @(posedge clk_in or posedge rst_in) begin
        if (rst_in) begin
            counter0_irq_out <= 1'b0;
        end else if (cross0) begin
            counter0_irq_out <= 1'b1; // R7 R9
        end else if (clr0) begin
            counter0_irq_out <= 1'b0; // R25
        end
    end

    always_ff @(posedge clk_in or posedge rst_in) begin
        if (rst_in) begin
            counter1_irq_out <= 1'b0;
        end else if (cross1) begin
            counter1_irq_out <= 1'b1; // R7 R9
        end else if (clr1) begin
            counter1_irq_out <= 1'b0; // R25
        end
    end

    // Requests go no faster than six cycles, which bounds the completed
    // instructions before service to twelve at dual issue.

    // Assertions
    ext_pin_a: assert property (@(posedge clk_in) disable iff (rst_in) // R18
        (counting && counter1_source_select_in == SRC1_EXT && $past(ext_sync[1]) == 1'b0
            && ext_sync[1]) |-> ev1)
        else $error("external pin event not selected");

    irq_hold0_a: assert property (@(posedge clk_in) disable iff (rst_in) // R25
        (counter0_irq_out && !clr0) |=> counter0_irq_out)
        else $error("counter 0 request dropped without clear");

    irq_hold1_a: assert property (@(posedge clk_in) disable iff (rst_in) // R9
        (counter1_irq_out && !clr1) |=> counter1_irq_out)
        else $error("counter 1 request dropped without clear");

    set_wins_a: assert property (@(posedge clk_in) disable iff (rst_in) // R8
        (cross0 && clr0) |=> counter0_irq_out)
        else $error("crossing lost under clear");

    delay_six_a: assert property (@(posedge clk_in) disable iff (rst_in) // R7
        (u_cnt0.carry) |-> ##6 counter0_irq_out)
        else $error("counter 0 request not six cycles after crossing");

    delay_six1_a: assert property (@(posedge clk_in) disable iff (rst_in) // R10
        (u_cnt1.carry) |-> ##6 counter1_irq_out)
        else $error("counter 1 request not six cycles after crossing");

    no_early_a: assert property (@(posedge clk_in) disable iff (rst_in) // R12
        (!counter1_irq_out && !cross1) |=> !counter1_irq_out)
        else $error("counter 1 request rose early");

    stop_cnt_a: assert property (@(posedge clk_in) disable iff (rst_in) // R4
        (!counting) |=> (u_cnt0.cnt_q == $past(u_cnt0.cnt_q))
            && (u_cnt1.cnt_q == $past(u_cnt1.cnt_q)))
        else $error("counter moved while disabled");

    count_up_a: assert property (@(posedge clk_in) disable iff (rst_in) // R5
        (counting && ev1) |=> u_cnt1.cnt_q == $past(u_cnt1.cnt_q) + 12'h001)
        else $error("counter 1 missed an event");

    short_thr_a: assert property (@(posedge clk_in) disable iff (rst_in) // R24
        (counting && ev1 && counter1_threshold_select_in
            && u_cnt1.cnt_q[7:0] == 8'hff) |-> u_cnt1.carry)
        else $error("counter 1 short threshold missed");

    long_thr_a: assert property (@(posedge clk_in) disable iff (rst_in) // R23
        (counting && ev0 && !counter0_threshold_select_in
            && u_cnt0.cnt_q != 16'hffff) |-> !u_cnt0.carry)
        else $error("counter 0 crossed early");

    clr_works0_a: assert property (@(posedge clk_in) disable iff (rst_in) // R25
        (counter0_irq_out && clr0 && !cross0) |=> !counter0_irq_out)
        else $error("counter 0 request not cleared");

    clr_works1_a: assert property (@(posedge clk_in) disable iff (rst_in) // R25
        (counter1_irq_out && clr1 && !cross1) |=> !counter1_irq_out)
        else $error("counter 1 request not cleared");

    set_wins1_a: assert property (@(posedge clk_in) disable iff (rst_in) // R8
        (cross1 && clr1) |=> counter1_irq_out)
        else $error("counter 1 crossing lost under clear");

    no_early0_a: assert property (@(posedge clk_in) disable iff (rst_in) // R7
        (!counter0_irq_out && !cross0) |=> !counter0_irq_out)
        else $error("counter 0 request rose early");

    count_up0_a: assert property (@(posedge clk_in) disable iff (rst_in) // R5
        (counting && ev0) |=> u_cnt0.cnt_q == $past(u_cnt0.cnt_q) + 16'h0001)
        else $error("counter 0 missed an event");

    idle0_a: assert property (@(posedge clk_in) disable iff (rst_in) // R1
        !(counting && ev0) |=> $stable(u_cnt0.cnt_q))
        else $error("counter 0 moved without an event");

    idle1_a: assert property (@(posedge clk_in) disable iff (rst_in) // R1
        !(counting && ev1) |=> $stable(u_cnt1.cnt_q))
        else $error("counter 1 moved without an event");

    short_thr0_a: assert property (@(posedge clk_in) disable iff (rst_in) // R23
        (counting && ev0 && counter0_threshold_select_in
            && u_cnt0.cnt_q[11:0] == 12'hfff) |-> u_cnt0.carry)
        else $error("counter 0 short threshold missed");

    long_hit0_a: assert property (@(posedge clk_in) disable iff (rst_in) // R23
        (counting && ev0 && !counter0_threshold_select_in
            && u_cnt0.cnt_q == 16'hffff) |-> u_cnt0.carry)
        else $error("counter 0 long threshold missed");

    long_thr1_a: assert property (@(posedge clk_in) disable iff (rst_in) // R24
        (counting && ev1 && !counter1_threshold_select_in
            && u_cnt1.cnt_q == 12'hfff) |-> u_cnt1.carry)
        else $error("counter 1 long threshold missed");

    quiet_carry0_a: assert property (@(posedge clk_in) disable iff (rst_in) // R26
        !(counting && ev0) |-> !u_cnt0.carry)
        else $error("counter 0 carry without an event");

    quiet_carry1_a: assert property (@(posedge clk_in) disable iff (rst_in) // R26
        !(counting && ev1) |-> !u_cnt1.carry)
        else $error("counter 1 carry without an event");

    dual_sel_a: assert property (@(posedge clk_in) disable iff (rst_in) // R19
        (counter1_source_select_in == SRC1_DUAL && issue_count_in == 2'd2) |-> ev1)
        else $error("dual issue not selected");

    cycle_sel_a: assert property (@(posedge clk_in) disable iff (rst_in) // R16
        (counter0_source_select_in == SRC0_CYCLES) |-> ev0)
        else $error("core cycle not selected");

    priv_sel_a: assert property (@(posedge clk_in) disable iff (rst_in) // R16
        (counter0_source_select_in == SRC0_PRIV) |-> (ev0 == privileged_code_mode_in))
        else $error("privileged mode cycle not selected");

    store_sel_a: assert property (@(posedge clk_in) disable iff (rst_in) // R22
        (counter1_source_select_in == SRC1_STORE) |-> (ev1 == store_in))
        else $error("store not selected");

    load_sel_a: assert property (@(posedge clk_in) disable iff (rst_in) // R14
        (counter0_source_select_in[3:1] == SRC0_LOAD) |-> (ev0 == load_in))
        else $error("load not selected");

    // Single issues must alternate the halving toggle, else pairs are miscounted
    half_pair_a: assert property (@(posedge clk_in) disable iff (rst_in) // R13
        (counting && counter0_source_select_in[3:1] == SRC0_ISSUE_HALF
            && issue_count_in == 2'd1) |=> (half_q != $past(half_q)))
        else $error("single issue did not toggle the halving state");
endmodule

//--- testbench/pevc_event_model.sv
// Behavioural model of the pipeline event sources and the external event pins
`timescale 1ns/1ps
module pevc_event_model (
    // Command from the bench
    input wire logic active_in,
    input wire logic [3:0] kind_in,
    // Pipeline events and pins
    output logic [1:0] issue_count_out,
    output logic [12:0] event_lines_out
);
    // Kinds 0-12 pulse one event line, d dual issue, e single issue, f no issue
    always_comb begin
        event_lines_out = '0;
        // Idle pipeline single-issues, so the non-issue code stays quiet; the halved issue code counts every other cycle
        issue_count_out = 2'h1;
        if (active_in) begin
            if (kind_in == 4'hd) begin
                issue_count_out = 2'h2;
            end else if (kind_in == 4'hf) begin
                issue_count_out = 2'h0;
            end else if (kind_in < 4'hd) begin
                // Pins present one event per core cycle, the shortest interval
                event_lines_out[kind_in] = 1'b1;
            end
        end
    end
endmodule

//--- testbench/testbench.sv
// Self-checking bench for the pipeline event counters
`timescale 1ns/1ps
module testbench;
    import pevc_pkg::*;
    logic clk_in = 1'b0;
    logic rst_in = 1'b1;
    logic [1:0] en = 2'h0;
    logic [3:0] sel0 = 4'h4;
    logic [2:0] sel1 = 3'h0;
    logic thr0 = 1'b1;
    logic thr1 = 1'b1;
    logic wr = 1'b0;
    logic clr0 = 1'b1;
    logic clr1 = 1'b1;
    logic active = 1'b0;
    logic [3:0] kind = 4'h0;
    logic [1:0] issue;
    logic [12:0] ev;
    logic irq0;
    logic irq1;
    int failures = 0;
    int total_checks = 0;
    int cycles = 0;
    int c0 = 0;
    int c1 = 0;
    always #12.5 clk_in = ~clk_in;
    pevc_event_model u_model (.active_in(active), .kind_in(kind),
        .issue_count_out(issue), .event_lines_out(ev));
    pevc_top u_dut (
        .clk_in(clk_in),
        .rst_in(rst_in),
        .counter_enable_pair_in(en),
        .counter0_source_select_in(sel0),
        .counter1_source_select_in(sel1),
        .counter0_threshold_select_in(thr0),
        .counter1_threshold_select_in(thr1),
        .interrupt_clear_register_wr_in(wr),
        .interrupt_clear_counter0_in(clr0),
        .interrupt_clear_counter1_in(clr1),
        .issue_count_in(issue),
        .dry_cycle_in(ev[0]),
        .load_in(ev[1]),
        .frozen_cycle_in(ev[2]),
        .branch_in(ev[3]),
        .privileged_code_mode_in(ev[4]),
        .dcache_miss_in(ev[5]),
        .icache_miss_in(ev[6]),
        .mispredict_in(ev[7]),
        .fp_operate_in(ev[8]),
        .int_operate_in(ev[9]),
        .store_in(ev[10]),
        .external_event_pins_in(ev[12:11]),
        .counter0_irq_out(irq0),
        .counter1_irq_out(irq1)
    );
    task automatic give_verdict;
        $display("checks %0d, failures %0d", total_checks, failures);
        if (failures == 0 && total_checks > 0)
            $display("DONE - PASS");
        else
            $display("DONE - FAIL");
        $finish;
    endtask
    always @(posedge clk_in) begin
        cycles++;
        if (cycles == 70000) begin
            failures++;
            give_verdict();
        end
    end
    task automatic check(input string what, input logic exp, input logic seen);
        total_checks++;
        if (seen !== exp) begin
            failures++;
            $display("unexpected %s: expected %b, seen %b", what, exp, seen);
        end
    endtask
    task automatic step(input int n);
        repeat (n) begin
            @(posedge clk_in);
            #1;
        end
    endtask
    task automatic emit(input logic [3:0] k, input int n);
        kind = k;
        active = n > 0;
        step(n);
        active = 1'b0;
    endtask
    // Enable drops two cycles after the last event so synchronised pins still land
    task automatic fire(input bit which, input logic [3:0] k, input int n, input int lo,
        input int hi);
        emit(k, n);
        step(2);
        en = 2'h0;
        step(lo - 3);
        check("irq early", 1'b0, which ? irq1 : irq0);
        step(hi - lo);
        check("irq", 1'b1, which ? irq1 : irq0);
    endtask
    task automatic clear(input bit which);
        wr = 1'b1;
        step(1);
        wr = 1'b0;
        check("irq kept", 1'b1, which ? irq1 : irq0);
        step(1);
        clr0 = which;
        clr1 = !which;
        wr = 1'b1;
        step(1);
        wr = 1'b0;
        clr0 = 1'b1;
        clr1 = 1'b1;
        check("irq cleared", 1'b0, which ? irq1 : irq0);
    endtask
    task automatic prep0(input int k);
        sel0 = 4'ha;
        en = 2'h3;
        step(k);
        en = 2'h0;
        c0 += k;
    endtask
    task automatic test_disabled;
        check("irq0 after reset", 1'b0, irq0);
        check("irq1 after reset", 1'b0, irq1);
        sel1 = 3'h6;
        emit(4'ha, 600);
        step(8);
        check("irq1 disabled", 1'b0, irq1);
        $display("disabled counting done");
    endtask
    task automatic test_counter1;
        logic [3:0] kinds [8] = '{4'h5, 4'h6, 4'hd, 4'h7, 4'h8, 4'h9, 4'ha, 4'hc};
        for (int code = 0; code < 8; code++) begin
            sel1 = 3'(code);
            en = 2'(code % 3 + 1);
            emit(kinds[code], 255 - c1 % 256);
            fire(1'b1, kinds[code], 1, code == 7 ? 7 : 5, code == 7 ? 8 : 6);
            c1 += 256 - c1 % 256;
            en = 2'h1;
            emit(kinds[code], 10);
            c1 += 10;
            clear(1'b1);
        end
        sel1 = 3'h6;
        thr1 = 1'b0;
        emit(4'ha, 4095 - c1 % 4096);
        fire(1'b1, 4'ha, 1, 5, 6);
        clear(1'b1);
        $display("counter one done");
    endtask
    task automatic test_counter0;
        logic [3:0] codes [9] = '{4'h0, 4'h3, 4'h4, 4'h7, 4'h8, 4'hb, 4'ha, 4'hc, 4'hf};
        logic [3:0] kinds [9] = '{4'hd, 4'h0, 4'h1, 4'h2, 4'h3, 4'h4, 4'he, 4'hf, 4'hb};
        // Idle single issues and idle cycles still count while enable is held
        int extra [9] = '{1, 0, 0, 0, 0, 0, 2, 0, 0};
        sel1 = 3'h0;
        for (int i = 0; i < 9; i++) begin
            prep0(4095 - c0 % 4096);
            sel0 = codes[i];
            en = 2'h2;
            // Halving phase is unknown here, so the crossing may come one cycle early
            if (i == 7)
                fire(1'b0, kinds[i], 2, 4, 6);
            else
                fire(1'b0, kinds[i], 1, i == 8 ? 7 : 5, i == 8 ? 8 : 6);
            c0 += 1 + extra[i];
            clear(1'b0);
        end
        thr0 = 1'b0;
        prep0(4095 - c0 % 4096);
        sel0 = 4'h4;
        en = 2'h1;
        emit(4'h1, 1);
        step(8);
        check("irq0 long range", 1'b0, irq0);
        en = 2'h0;
        $display("counter zero done");
    endtask
    initial begin
        step(20);
        rst_in = 1'b0;
        step(1);
        test_disabled();
        test_counter1();
        test_counter0();
        give_verdict();
    end
endmodule
